// file: shared/gsl_pkg.sv
// constants, types and register map of the global shutdown, low-power
// and interrupt logic; assumes one 250 MHz clock and an Avalon-MM host
// Operation
// RL1: any global shutdown turns all regulators off and resets most registers
// RL2: reset pin held low externally for debounce time raises shutdown
// RL3: writing the soft reset bit raises a software-reset shutdown
// RL4: battery undervoltage triggers global shutdown
// RL5: low-battery indication triggers shutdown only with its enable bit set
// RL6: overvoltage on battery or buck analog supply triggers shutdown
// RL7: thermal overload triggers global shutdown
// RL8: wake key held low past selected manual reset time triggers shutdown
// RL9: shutdown cause log records each cause and survives global shutdown
// RL10: real-time clock keeps running through any global shutdown
// RL11: power-up after shutdown only with battery and temperature valid
// RL12: three fault events power down in sequence, then wake automatically
// RL13: five events power down in sequence and stay off until a wakeup; code has four (manual reset, shutdown pin, power-off bit, soft reset)
// RL14: soft reset with wake select zero ends off awaiting a wakeup
// RL15: five hazardous events shut down at once and reset all registers; code keeps the cause log
// RL16: each regulator and oscillator power mode set singly or globally
// RL17: power mode 0b01 means low power while the low-power line is high
// RL18: while reset output is asserted the sleep request is forced low
// RL19: without reset output and mask clear, sleep input drives sleep request
// RL20: top interrupt register has eight bits set by sub-block flags
// RL21: reading the top interrupt register clears it
// RL22: setting the global mask releases the interrupt pin
// RL23: events under global mask are still latched
// RL24: clearing global mask with pending flags drives interrupt low again
// RL25: per-event masks gate only the interrupt pin, never the flags
// RL26: shutdown caused by the reset pin ends with automatic wakeup
// RL27: low-power line is OR of global bit, pin alternate input, sleep
// RL28: immediate shutdown wins over the sequenced categories
package gsl_pkg;
    localparam int NUM_PERIPH = 14; // 4 buck, 9 ldo, oscillator

    localparam logic [4:0] CTRL_OFS   = 5'h00;
    localparam logic [4:0] IRQCFG_OFS = 5'h04;
    localparam logic [4:0] TOPIRQ_OFS = 5'h08;
    localparam logic [4:0] CAUSE_OFS  = 5'h0c;
    localparam logic [4:0] STAT_OFS   = 5'h10;
    localparam logic [4:0] PMODE_OFS  = 5'h14;

    localparam int SFTRST_BIT = 0;
    localparam int PWROFF_BIT = 1;
    localparam int SRWAKE_BIT = 2;
    localparam int LBSHDN_BIT = 3;
    localparam int MANUAL_RESET_EN_BIT   = 4;
    localparam int MRT_LSB    = 5;
    localparam int GLPM_BIT   = 8;
    localparam int GPSEL_BIT  = 9;
    localparam int SLPMSK_BIT = 10;
    localparam int GMASK_BIT  = 0;
    localparam int EVMASK_LSB = 8;

    localparam logic [10:0] CTRL_RST   = 11'h000;
    localparam logic [8:0]  IRQCFG_RST = 9'h001;
    localparam logic [27:0] PMODE_RST  = 28'h0000000;
    localparam logic [1:0]  PM_LOWPWR  = 2'h1;

    // time figures and cycle counts at 4 ns
    localparam int CLK_NS        = 4;
    localparam int DEBOUNCE_NS   = 30000;
    localparam int DEBOUNCE_CYC  = (DEBOUNCE_NS + CLK_NS - 1) / CLK_NS;
    localparam int TICK_NS       = 1000000;
    localparam int TICK_CYC      = TICK_NS / CLK_NS;
    localparam logic [17:0] MR_BASE_TICKS = 18'h003e8; // 1000 ticks of 1 ms

    // cause log bit positions
    localparam int C_RSI = 0, C_SFT = 1, C_UV = 2, C_LOWB = 3, C_OVB = 4;
    localparam int C_OVA = 5, C_THERM = 6, C_MR = 7, C_WDT = 8;
    localparam int C_SHUTDOWN_PIN = 9, C_PWROFF = 10;

    typedef enum logic [2:0] {
        ST_OFF  = 3'b000,
        ST_UP   = 3'b001,
        ST_ON   = 3'b011,
        ST_SEQ  = 3'b010,
        ST_SHUTDOWN_PIN = 3'b110
    } gsl_state_e;

    typedef struct packed {
        logic battUv;
        logic lowBatt;
        logic ovBatt;
        logic ovAvsd;
        logic thermal;
        logic watchdog;
        logic shutdownPin;
    } gsl_faults_s;
endpackage

// file: rtl/gsl_global_logic.sv
// global shutdown sequencing, global low-power line and top interrupt
// assumes power sequencer handshakes on sys_clk; pins are asynchronous
`timescale 1ns/10ps
module gsl_global_logic #(
    parameter int DEBOUNCE_CYCLES = gsl_pkg::DEBOUNCE_CYC,
    parameter int TICK_CYCLES     = gsl_pkg::TICK_CYC
) (
    // clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 rst_n,
    // avalon-mm slave
    input  wire logic [4:0]           address,
    input  wire logic                 read,
    input  wire logic                 write,
    input  wire logic [31:0]          writedata,
    output logic [31:0]               readdata,
    output logic                      waitrequest,
    // fault and monitor pins
    input  wire gsl_pkg::gsl_faults_s faultsAsync,
    input  wire logic                 battValidAsync,
    input  wire logic                 tempValidAsync,
    // bidirectional reset pin
    input  wire logic                 bidirResetPinIn,
    output logic                      bidirResetPinOut,
    output logic                      bidirResetPinOe,
    // wake, sleep and general pin
    input  wire logic                 wakeKeyInputAsync,
    input  wire logic                 rtcAlarmWake,
    input  wire logic                 sleepInputAsync,
    input  wire logic                 firstGpPinAsync,
    // power sequencer handshake
    output logic                      regulatorsEn,
    output logic                      seqDownReq,
    input  wire logic                 seqDownDone,
    output logic                      powerUpReq,
    input  wire logic                 powerUpDone,
    output logic                      gsdRegReset,
    // low-power control
    output logic                      lowpowerLine,
    output logic [13:0]               periphLowPower,
    // interrupts
    input  wire logic [7:0]           subBlockFlags,
    output logic                      irqOutN,
    output logic                      irqOutOe
);
    import gsl_pkg::*;

    // two-flop synchronisers for all pin inputs
    logic [11:0] syncA_reg;
    logic [11:0] syncB_reg;
    logic [11:0] pinRaw;
    assign pinRaw = {faultsAsync, battValidAsync, tempValidAsync,
                     bidirResetPinIn, wakeKeyInputAsync,
                     firstGpPinAsync};

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            syncA_reg <= 12'h006;
            syncB_reg <= 12'h006;
        end
        else
        begin
            syncA_reg <= pinRaw;
            syncB_reg <= syncA_reg;
        end
    end

    gsl_faults_s faults;
    logic battValid, tempValid, rstPin, wakeKey, gpPin, sleepIn;
    logic sleepA_reg, sleepB_reg;
    assign faults    = gsl_faults_s'(syncB_reg[11:5]);
    assign battValid = syncB_reg[4];
    assign tempValid = syncB_reg[3];
    assign rstPin    = syncB_reg[2];
    assign wakeKey   = syncB_reg[1];
    assign gpPin     = syncB_reg[0];
    assign sleepIn   = sleepB_reg;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sleepA_reg <= 1'b0;
            sleepB_reg <= 1'b0;
        end
        else
        begin
            sleepA_reg <= sleepInputAsync;
            sleepB_reg <= sleepA_reg;
        end
    end

    // registers
    gsl_state_e  state_reg;
    logic [10:0] ctrl_reg;
    logic [8:0]  irqCfg_reg;
    logic [7:0]  topIrq_reg;
    logic [10:0] cause_reg;
    logic [27:0] pmode_reg;
    logic        ack_reg;
    logic        autoWake_reg;
    logic        gsdRst;
    logic        wrAcc, rdAcc;
    logic        resetOutAssert;

    assign gsdRst = (state_reg == ST_SHUTDOWN_PIN);
    assign resetOutAssert = (state_reg != ST_ON);

    // bus slave: one wait cycle, then accept
    assign waitrequest = (read | write) & ~ack_reg;
    assign wrAcc = write & ack_reg;
    assign rdAcc = read & ack_reg;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            ack_reg <= 1'b0;
        else
            ack_reg <= (read | write) & ~ack_reg;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            readdata <= 32'h00000000;
        else if (read & ~ack_reg)
        begin
            case (address)
                CTRL_OFS:   readdata <= {21'h000000, ctrl_reg};
                IRQCFG_OFS: readdata <= {16'h0000, irqCfg_reg[8:1],
                                         7'h00, irqCfg_reg[0]};
                TOPIRQ_OFS: readdata <= {24'h000000, topIrq_reg};
                CAUSE_OFS:  readdata <= {21'h000000, cause_reg};
                STAT_OFS:   readdata <= {24'h000000, battValid, tempValid,
                                         resetOutAssert, lowpowerLine,
                                         autoWake_reg, state_reg};
                PMODE_OFS:  readdata <= {4'h0, pmode_reg};
                default:    readdata <= 32'h00000000;
            endcase
        end
    end

    // control register; soft reset bit self-clears
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            ctrl_reg <= CTRL_RST;
        else if (gsdRst)
            ctrl_reg <= CTRL_RST; // see RL1
        else if (wrAcc && address == CTRL_OFS)
            ctrl_reg <= writedata[10:0];
        else
        begin
            ctrl_reg[SFTRST_BIT] <= 1'b0;
            ctrl_reg[PWROFF_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            irqCfg_reg <= IRQCFG_RST;
        else if (gsdRst)
            irqCfg_reg <= IRQCFG_RST; // see RL1
        else if (wrAcc && address == IRQCFG_OFS)
            irqCfg_reg <= {writedata[15:8], writedata[0]};
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            pmode_reg <= PMODE_RST;
        else if (gsdRst)
            pmode_reg <= PMODE_RST; // see RL1
        else if (wrAcc && address == PMODE_OFS)
            pmode_reg <= writedata[27:0]; // see RL16
    end

    // debounce of external low on reset pin
    logic        rsiDetect;
    logic [15:0] dbCnt_reg;
    logic        rsiEvent;
    assign rsiDetect = ~rstPin & ~resetOutAssert;
    assign rsiEvent  = (dbCnt_reg == 16'(DEBOUNCE_CYCLES)); // see RL2

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            dbCnt_reg <= 16'h0000;
        else if (!rsiDetect)
            dbCnt_reg <= 16'h0000;
        else if (!rsiEvent)
            dbCnt_reg <= dbCnt_reg + 16'h0001; // see RL2
    end

    // manual reset: millisecond ticks while wake key low
    logic [17:0] tickCnt_reg;
    logic [17:0] mrCnt_reg;
    logic [17:0] mrLimit;
    logic        tick, mrEvent;
    assign tick    = (tickCnt_reg == 18'(TICK_CYCLES - 1));
    assign mrLimit = MR_BASE_TICKS << ctrl_reg[MRT_LSB +: 3];
    assign mrEvent = ctrl_reg[MANUAL_RESET_EN_BIT] & (mrCnt_reg >= mrLimit); // see RL8

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            tickCnt_reg <= 18'h00000;
        else if (tick || wakeKey)
            tickCnt_reg <= 18'h00000;
        else
            tickCnt_reg <= tickCnt_reg + 18'h00001;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            mrCnt_reg <= 18'h00000;
        else if (wakeKey)
            mrCnt_reg <= 18'h00000;
        else if (tick && !mrEvent)
            mrCnt_reg <= mrCnt_reg + 18'h00001; // see RL8
    end

    // shutdown sources sorted by category
    logic [10:0] causeNow;
    logic        immEvt, autoEvt, offEvt, sftRst;
    assign sftRst = ctrl_reg[SFTRST_BIT]; // see RL3
    always_comb
    begin
        causeNow           = 11'h000;
        causeNow[C_RSI]    = rsiEvent;
        causeNow[C_SFT]    = sftRst;
        causeNow[C_UV]     = faults.battUv; // see RL4
        causeNow[C_LOWB]   = faults.lowBatt & ctrl_reg[LBSHDN_BIT]; // see RL5
        causeNow[C_OVB]    = faults.ovBatt; // see RL6
        causeNow[C_OVA]    = faults.ovAvsd; // see RL6
        causeNow[C_THERM]  = faults.thermal; // see RL7
        causeNow[C_MR]     = mrEvent;
        causeNow[C_WDT]    = faults.watchdog;
        causeNow[C_SHUTDOWN_PIN]   = faults.shutdownPin;
        causeNow[C_PWROFF] = ctrl_reg[PWROFF_BIT];
    end
    // see RL15
    assign immEvt  = causeNow[C_UV] | causeNow[C_OVB] | causeNow[C_OVA]
                   | causeNow[C_THERM] | causeNow[C_LOWB];
    // see RL12
    assign autoEvt = causeNow[C_RSI] | causeNow[C_WDT]
                   | (sftRst & ctrl_reg[SRWAKE_BIT]);
    // see RL13
    assign offEvt  = causeNow[C_MR] | causeNow[C_SHUTDOWN_PIN] | causeNow[C_PWROFF]
                   | (sftRst & ~ctrl_reg[SRWAKE_BIT]); // see RL14

    logic live, takeImm, takeSeq;
    assign live    = (state_reg != ST_OFF) && (state_reg != ST_SHUTDOWN_PIN);
    assign takeImm = live & immEvt; // see RL28
    assign takeSeq = (state_reg == ST_ON) & ~immEvt & (autoEvt | offEvt);

    // nonvolatile cause log, write one to clear, reset by rst_n but not by global shutdown
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            cause_reg <= 11'h000;
        else if (takeImm || takeSeq)
            cause_reg <= cause_reg | causeNow; // see RL9
        else if (wrAcc && address == CAUSE_OFS)
            cause_reg <= cause_reg & ~writedata[10:0];
    end

    // global shutdown state machine
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            autoWake_reg <= 1'b0;
        else if (takeImm)
            autoWake_reg <= 1'b0;
        else if (takeSeq)
            autoWake_reg <= autoEvt; // see RL26
        else if (state_reg == ST_UP)
            autoWake_reg <= 1'b0;
    end

    logic pwrOk;
    assign pwrOk = battValid & tempValid; // see RL11

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            state_reg <= ST_OFF;
        else if (takeImm)
            state_reg <= ST_SHUTDOWN_PIN; // see RL15
        else
        begin
            case (state_reg)
                ST_OFF:
                    if (pwrOk && (!wakeKey || rtcAlarmWake))
                        state_reg <= ST_UP; // see RL13, RL10
                ST_UP:
                    if (powerUpDone)
                        state_reg <= ST_ON;
                ST_ON:
                    if (takeSeq)
                        state_reg <= ST_SEQ;
                ST_SEQ:
                    if (seqDownDone)
                        state_reg <= ST_SHUTDOWN_PIN;
                ST_SHUTDOWN_PIN:
                    if (autoWake_reg && pwrOk)
                        state_reg <= ST_UP; // see RL12
                    else
                        state_reg <= ST_OFF; // see RL14
                default:
                    state_reg <= ST_OFF;
            endcase
        end
    end

    // sequencer outputs
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            regulatorsEn <= 1'b0;
            seqDownReq   <= 1'b0;
            powerUpReq   <= 1'b0;
            gsdRegReset  <= 1'b0;
        end
        else
        begin
            regulatorsEn <= (state_reg == ST_ON) & ~takeImm
                          | (state_reg == ST_SEQ) & ~takeImm; // see RL1
            seqDownReq   <= (state_reg == ST_SEQ) & ~takeImm;
            powerUpReq   <= (state_reg == ST_UP) & ~takeImm;
            gsdRegReset  <= gsdRst; // see RL1
        end
    end

    // reset pin driven low while the reset output is asserted
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            bidirResetPinOe <= 1'b1;
        else
            bidirResetPinOe <= resetOutAssert;
    end
    assign bidirResetPinOut = 1'b0;

    // global low-power line
    logic sleepReq;
    logic lplNext;
    assign sleepReq = ~resetOutAssert & ~ctrl_reg[SLPMSK_BIT]
                    & sleepIn; // see RL18 // see RL19
    assign lplNext  = ctrl_reg[GLPM_BIT] | (ctrl_reg[GPSEL_BIT] & gpPin)
                    | sleepReq; // see RL27

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            lowpowerLine <= 1'b0;
        else
            lowpowerLine <= lplNext;
    end

    wire [13:0] lpWant;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PERIPH; gi++)
        begin : g_lp
            assign lpWant[gi] = (pmode_reg[2*gi +: 2] == PM_LOWPWR)
                              & lplNext; // see RL17
        end
    endgenerate
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            periphLowPower <= 14'h0000;
        else
            periphLowPower <= lpWant;
    end

    // top interrupt flags: rising sub-block flag sets, read clears
    logic [7:0] subPrev_reg;
    logic [7:0] subRise;
    assign subRise = subBlockFlags & ~subPrev_reg;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            subPrev_reg <= 8'h00;
        else
            subPrev_reg <= subBlockFlags;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            topIrq_reg <= 8'h00;
        else if (gsdRst)
            topIrq_reg <= 8'h00;
        else if (rdAcc && address == TOPIRQ_OFS)
            topIrq_reg <= subRise; // see RL21 // see RL20
        else
            topIrq_reg <= topIrq_reg | subRise; // see RL23
    end

    // open-drain interrupt pin
    logic irqPend;
    assign irqPend = |(topIrq_reg & ~irqCfg_reg[8:1]); // see RL25

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            irqOutOe <= 1'b0;
        else
            irqOutOe <= irqPend & ~irqCfg_reg[GMASK_BIT]; // see RL22 // see RL24
    end
    assign irqOutN = 1'b0;

endmodule // gsl_global_logic

// file: verification/gsl_global_logic_sva.sv
// assertions on the ports of the global shutdown and irq logic
// bound from tb; one clock domain, async active-low reset
`timescale 1ns/10ps
module gsl_global_logic_sva (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst_n,
    // register bus
    input wire logic [4:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic        waitrequest,
    // sequencer and outputs
    input wire logic        seqDownReq,
    input wire logic        seqDownDone,
    input wire logic        gsdRegReset,
    input wire logic        regulatorsEn,
    input wire logic        lowpowerLine,
    input wire logic [13:0] periphLowPower,
    input wire logic [7:0]  subBlockFlags,
    input wire logic        irqOutOe
);
    import gsl_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    wait_start_a: assert property ( // bus handshake
        $rose(read || write) |-> waitrequest)
        else $error("request accepted without a wait cycle");
    wait_end_a: assert property ( // bus handshake
        (read || write) && waitrequest |=> !waitrequest || !(read || write))
        else $error("request waited more than one cycle");
    gmask_release_a: assert property (
        write && !waitrequest && address == IRQCFG_OFS
        && writedata[GMASK_BIT] |-> ##2 !irqOutOe)
        else $error("irq pin still driven after global mask");
    read_clear_a: assert property (
        read && !waitrequest && address == TOPIRQ_OFS
        && $stable(subBlockFlags) ##1 $stable(subBlockFlags) [*2]
        |-> !irqOutOe)
        else $error("irq pin driven after top flags read");
    lp_gate_a: assert property (
        !lowpowerLine [*2] |-> periphLowPower == 14'h0000)
        else $error("peripheral low power without low-power line");
    regs_off_a: assert property (
        gsdRegReset |-> !regulatorsEn && !seqDownReq)
        else $error("regulators on during shutdown reset");
    pulse_one_a: assert property (
        gsdRegReset |=> !gsdRegReset)
        else $error("shutdown reset longer than one cycle");
    seq_done_a: assert property (
        seqDownReq && seqDownDone |-> ##[1:3] gsdRegReset)
        else $error("no shutdown reset after sequenced power-down");
endmodule // gsl_global_logic_sva

// file: verification/gsl_seq_model.sv
// power sequencer stand-in answering power-down and power-up requests
// same clock as the global logic; slow selects a late answer
`timescale 1ns/10ps
module gsl_seq_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // requests and answers
    input wire logic seqDownReq,
    input wire logic powerUpReq,
    input wire logic slow,
    output logic     seqDownDone,
    output logic     powerUpDone
);
    logic [3:0] cntReg;
    logic [3:0] lim;
    assign lim = slow ? 4'h9 : 4'h1;
    // count cycles of a live request
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            cntReg <= 4'h0;
        else if (!(seqDownReq || powerUpReq))
            cntReg <= 4'h0;
        else if (cntReg != 4'hf)
            cntReg <= cntReg + 4'h1;
    end
    // answer once the delay has run out
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            seqDownDone <= 1'b0;
            powerUpDone <= 1'b0;
        end
        else
        begin
            seqDownDone <= seqDownReq && cntReg >= lim;
            powerUpDone <= powerUpReq && cntReg >= lim;
        end
    end
endmodule // gsl_seq_model

// file: verification/tb.sv
// self-checking bench for the global shutdown, low-power and irq logic
// drives pins and the avalon-mm slave; a model answers the sequencer
`timescale 1ns/10ps
module tb;
    import gsl_pkg::*;
    logic sys_clk = 1'b0, rst_n = 1'b0, read = 1'b0, write = 1'b0;
    logic [4:0] address = 5'h00;
    logic [31:0] writedata = 32'h0, readdata, rd;
    logic waitrequest, regulatorsEn, seqDownReq, seqDownDone;
    logic powerUpReq, powerUpDone, gsdRegReset, lowpowerLine;
    logic [13:0] periphLowPower;
    gsl_faults_s faultsAsync = 7'h00;
    logic battValidAsync = 1'b0, tempValidAsync = 1'b1, extRst = 1'b1;
    logic wakeKeyInputAsync = 1'b1, rtcAlarmWake = 1'b0, slow = 1'b0;
    logic sleepInputAsync = 1'b0, firstGpPinAsync = 1'b0;
    logic [7:0] subBlockFlags = 8'h00;
    logic irqOutN, irqOutOe, bidirResetPinOut, bidirResetPinOe;
    wire bidirResetPinIn;
    int fails = 0, comparisons = 0, cyc = 0;
    // open-drain reset pin with pull-up
    assign bidirResetPinIn = bidirResetPinOe ? bidirResetPinOut : extRst;
    gsl_global_logic #(.DEBOUNCE_CYCLES(8), .TICK_CYCLES(4)) dut_u (.*);
    gsl_seq_model seq_u (.*);
    always #2 sys_clk = ~sys_clk;
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            fails++;
            end_sim();
        end
    end
    task automatic chk(input string what, input logic [31:0] got, exp);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic bus(input logic wr, input logic [4:0] a,
        input logic [31:0] d);
        @(posedge sys_clk);
        address <= a;
        read <= !wr;
        write <= wr;
        writedata <= d;
        @(posedge sys_clk);
        while (waitrequest !== 1'b0)
            @(posedge sys_clk);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic rdchk(input string nm, input logic [4:0] a,
        input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(nm, rd, exp);
    endtask
    task automatic power_up();
        int n;
        rtcAlarmWake <= 1'b1;
        tick(4);
        rtcAlarmWake <= 1'b0;
        n = 0;
        while (regulatorsEn !== 1'b1 && n < 100)
        begin
            tick(1);
            n++;
        end
        chk("regulators on", {31'h0, regulatorsEn}, 32'h1);
    endtask
    task automatic lp(input logic [31:0] ctl, input logic exp);
        bus(1'b1, CTRL_OFS, ctl);
        tick(20);
        chk("lowpower line", {31'h0, lowpowerLine}, {31'h0, exp});
    endtask
    task automatic ev(input string nm, input logic [6:0] f,
        input logic [10:0] ctl, input logic [1:0] pins, input int hold,
        input logic [10:0] cause, input logic [2:0] st);
        power_up();
        bus(1'b1, CAUSE_OFS, 32'h7ff);
        bus(1'b1, CTRL_OFS, {21'h0, ctl});
        faultsAsync <= f;
        extRst <= !pins[1];
        wakeKeyInputAsync <= !pins[0];
        tick(hold);
        faultsAsync <= 7'h00;
        extRst <= 1'b1;
        wakeKeyInputAsync <= 1'b1;
        tick(60);
        rdchk({nm, " cause"}, CAUSE_OFS, {21'h0, cause});
        bus(1'b0, STAT_OFS, 32'h0);
        chk({nm, " state"}, {29'h0, rd[2:0]}, {29'h0, st});
        rd = {30'h0, bidirResetPinOut, bidirResetPinOe};
        chk({nm, " reset pin"}, rd, {31'h0, st != ST_ON});
        $display("test %s done", nm);
    endtask
    initial
    begin
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        rdchk("ctrl reset", CTRL_OFS, 32'h0);
        rdchk("irqcfg reset", IRQCFG_OFS, 32'h1);
        rdchk("pmode reset", PMODE_OFS, 32'h0);
        bus(1'b1, 5'h18, 32'hffffffff);
        rdchk("unmapped", 5'h18, 32'h0);
        wakeKeyInputAsync <= 1'b0;
        tick(4);
        wakeKeyInputAsync <= 1'b1;
        tick(30);
        chk("no power-up", {31'h0, regulatorsEn}, 32'h0);
        $display("test reset done");
        battValidAsync <= 1'b1;
        power_up();
        bus(1'b1, PMODE_OFS, 32'h04000001);
        firstGpPinAsync <= 1'b1;
        lp(32'h100, 1'b1);
        chk("periph lp", {18'h0, periphLowPower}, 32'h2001);
        lp(32'h200, 1'b1);
        lp(32'h0, 1'b0);
        sleepInputAsync <= 1'b1;
        lp(32'h0, 1'b1);
        lp(32'h400, 1'b0);
        lp(32'h2, 1'b0);
        sleepInputAsync <= 1'b0;
        firstGpPinAsync <= 1'b0;
        $display("test low-power done");
        power_up();
        for (int i = 0; i < 8; i++)
        begin
            subBlockFlags <= 8'h01 << i;
            tick(2);
            subBlockFlags <= 8'h00;
            rdchk("top flag", TOPIRQ_OFS, 32'h1 << i);
            chk("irq masked", {31'h0, irqOutOe}, 32'h0);
        end
        rdchk("top cleared", TOPIRQ_OFS, 32'h0);
        subBlockFlags <= 8'h20;
        bus(1'b1, IRQCFG_OFS, 32'h2000);
        tick(3);
        chk("irq event mask", {31'h0, irqOutOe}, 32'h0);
        rdchk("top under mask", TOPIRQ_OFS, 32'h20);
        subBlockFlags <= 8'h21;
        tick(3);
        chk("irq unmasked", {30'h0, irqOutN, irqOutOe}, 32'h1);
        bus(1'b1, IRQCFG_OFS, 32'h1);
        tick(3);
        chk("irq released", {31'h0, irqOutOe}, 32'h0);
        bus(1'b1, IRQCFG_OFS, 32'h0);
        tick(3);
        chk("irq unmask again", {31'h0, irqOutOe}, 32'h1);
        subBlockFlags <= 8'h00;
        $display("test interrupts done");
        ev("uv", 7'h40, 11'h0, 2'b00, 4, 11'h004, ST_OFF);
        ev("lowb off", 7'h20, 11'h0, 2'b00, 4, 11'h000, ST_ON);
        ev("lowb", 7'h20, 11'h8, 2'b00, 4, 11'h008, ST_OFF);
        ev("ovb", 7'h10, 11'h0, 2'b00, 4, 11'h010, ST_OFF);
        ev("ova", 7'h08, 11'h0, 2'b00, 4, 11'h020, ST_OFF);
        ev("therm", 7'h04, 11'h0, 2'b00, 4, 11'h040, ST_OFF);
        ev("pin", 7'h01, 11'h0, 2'b00, 4, 11'h200, ST_OFF);
        ev("sft", 7'h00, 11'h1, 2'b00, 1, 11'h002, ST_OFF);
        ev("poff", 7'h00, 11'h2, 2'b00, 1, 11'h400, ST_OFF);
        slow <= 1'b1;
        ev("wdt", 7'h02, 11'h0, 2'b00, 4, 11'h100, ST_ON);
        ev("sftwk", 7'h00, 11'h5, 2'b00, 1, 11'h002, ST_ON);
        ev("rsi", 7'h00, 11'h0, 2'b10, 14, 11'h001, ST_ON);
        ev("mr", 7'h00, 11'h10, 2'b01, 4100, 11'h080, ST_ON);
        end_sim();
    end
endmodule // tb
bind gsl_global_logic gsl_global_logic_sva chk_u (.*);
